//--- pkg/rsti_pkg.sv
/*
  Constants, field layouts and carrier types of the receive system TDM interface.
  Assumes a 32-bit plain register port and one link clock domain beside the system clock.
*/
`default_nettype none
package rsti_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_MODE = 8'h40;
  localparam logic [7:0] ADDR_STAT = 8'h44;
  localparam logic [7:0] ADDR_POL = 8'h48;
  localparam int POL_INV_BIT = 4;
  localparam int MODE_MUX_BIT = 0;
  localparam int MODE_MASTER_BIT = 1;
  localparam int MODE_E1_BIT = 2;
  localparam int MODE_EVT_LSB = 4;
  localparam int MODE_SLOT_LSB = 8;
  localparam logic [31:0] MODE_RESET = 32'h0;
  localparam logic [31:0] POL_RESET = 32'h0;
  // ==========================================================
  // frame geometry
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [4:0] T1_CHAN_LAST = 5'h17;
  localparam logic [4:0] E1_CHAN_LAST = 5'h1f;
  localparam logic [4:0] E1_TS1 = 5'h01;
  localparam logic [4:0] E1_TS16 = 5'h10;
  localparam logic [1:0] LINK_LAST = 2'h3;
  localparam logic [2:0] SIG_FIRST_BIT = 3'h4;
  // ==========================================================
  // frame pulse event codes
  localparam logic [2:0] EVT_EVERY = 3'h0;
  localparam logic [2:0] EVT_SECOND = 3'h1;
  localparam logic [2:0] EVT_MF = 3'h2;
  localparam logic [2:0] EVT_SECOND_MF = 3'h3;
  localparam logic [2:0] EVT_E1_CRC_MF = 3'h1;
  localparam logic [2:0] EVT_E1_SIG_MF = 3'h2;
  localparam logic [2:0] EVT_E1_BOTH = 3'h3;
  localparam logic [2:0] EVT_E1_TS = 3'h4;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] sig;
  } rsti_chan_t;
  typedef struct packed {
    logic mux;
    logic master;
    logic e1;
    logic [2:0] evt;
    logic pol_inv;
    logic [1:0] slot;
  } rsti_cfg_t;
endpackage
`default_nettype wire

//--- design/rsti_top.sv
/*
  Receive system TDM interface: serialises channel bytes and signaling nibbles onto the
  system backplane, non-multiplexed or byte-interleaved multiplexed, with frame pulse.
  Assumes the framer core runs on the link clock and answers channel requests in time.
*/
// Contract
// R1: in non-multiplexed mode the serial data output changes only on the active link edge.
// R2: in multiplexed mode the link's bytes go into their interleaved slot, updated on the bus clock.
// R3: signaling bits sit in b5 to b8 of each channel, in the slot of the matching data byte.
// R4: in non-multiplexed mode the signaling output changes only on the active edge, aligned with data.
// R5: in multiplexed mode signaling nibbles are interleaved and aligned with the multiplexed data.
// R6: in T1/J1 master mode the frame pulse marks one selectable F-bit event.
// R7: in T1/J1 slave mode an external pulse, a multiple of 125 us apart, starts a frame.
// R8: in E1 master mode the frame pulse marks basic frame, CRC, signaling, both, or TS1/TS16.
// R9: in E1 slave mode an external pulse, a multiple of 125 us apart, starts a frame.
// R10: the non-multiplexed frame pulse is driven or sampled on the active link clock edge.
// R11: bit 4 of register 048H inverts the active level of the non-multiplexed frame pulse.
// R12: in multiplexed mode the bus frame-start pulse is sampled on the bus clock edge.
// R13: the multiplexed frame-start input uses the same polarity-invert bit.
// R14: in master mode the block drives a possibly gapped system clock timing data and pulse.
// R15: in slave mode the partner supplies a 1.544, 2.048 or 4.096 MHz system clock.
// R16: in multiplexed mode the partner supplies an 8.192 or 16.384 MHz bus clock.
// R17: the driven frame pulse is one system clock cycle wide, in the bit of the marked event.
`timescale 1ns/100ps
`default_nettype none
module rsti_top (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  input wire logic i_clk_link,
  input wire logic i_rx_gap,
  input wire logic i_rx_frame_start,
  input wire logic i_rx_mf_start,
  input wire logic i_rx_sig_mf_start,
  input wire logic i_rx_fbit,
  input wire rsti_pkg::rsti_chan_t i_chan,
  output logic o_chan_req,
  output logic [4:0] o_chan_idx,
  output logic o_rx_sys_clock,
  output logic o_rx_sys_clock_oe,
  output logic o_rx_sys_data,
  output logic o_rx_sys_signaling,
  input wire logic i_rx_sys_frame_pulse,
  output logic o_rx_sys_frame_pulse,
  output logic o_rx_sys_frame_pulse_oe,
  input wire logic i_rx_bus_frame_pulse_muxed,
  output logic o_rx_bus_data_muxed,
  output logic o_rx_bus_data_muxed_oe,
  output logic o_rx_bus_signaling_muxed,
  output logic o_rx_bus_signaling_muxed_oe
);
  // ==========================================================
  // register port, system domain
  logic [31:0] mode_reg;
  logic [31:0] pol_reg;
  logic [15:0] frame_count;
  rsti_pkg::rsti_cfg_t cfg_sys;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      mode_reg <= rsti_pkg::MODE_RESET;
      pol_reg <= rsti_pkg::POL_RESET;
    end
    else if (i_wr)
    begin
      if (i_addr == rsti_pkg::ADDR_MODE)
        mode_reg <= i_wr_data;
      if (i_addr == rsti_pkg::ADDR_POL)
        pol_reg <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
      o_rd_data <= 32'h0;
    else if (i_rd)
    begin
      unique case (i_addr)
        rsti_pkg::ADDR_MODE: o_rd_data <= mode_reg;
        rsti_pkg::ADDR_POL: o_rd_data <= pol_reg;
        rsti_pkg::ADDR_STAT: o_rd_data <= {16'h0, frame_count};
        default: o_rd_data <= 32'h0;
      endcase
    end
    else
      o_rd_data <= 32'h0;
  end

  always_comb
  begin
    cfg_sys.mux = mode_reg[rsti_pkg::MODE_MUX_BIT];
    cfg_sys.master = mode_reg[rsti_pkg::MODE_MASTER_BIT];
    cfg_sys.e1 = mode_reg[rsti_pkg::MODE_E1_BIT];
    cfg_sys.evt = mode_reg[rsti_pkg::MODE_EVT_LSB +: 3];
    cfg_sys.pol_inv = pol_reg[rsti_pkg::POL_INV_BIT];
    cfg_sys.slot = mode_reg[rsti_pkg::MODE_SLOT_LSB +: 2];
  end

  // ==========================================================
  // crossings
  // configuration is quasi-static: software changes it only while the link is idle,
  // so a plain two-flop pass per bit is accepted instead of a handshake
  logic lrst_meta;
  logic lrst_n;
  rsti_pkg::rsti_cfg_t cfg_meta;
  rsti_pkg::rsti_cfg_t cfg_l;
  logic frame_tgl;
  logic [2:0] tgl_sync;

  always_ff @(posedge i_clk_link)
  begin
    lrst_meta <= i_resetn;
    lrst_n <= lrst_meta;
  end

  always_ff @(posedge i_clk_link)
  begin
    cfg_meta <= cfg_sys;
    cfg_l <= cfg_meta;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      tgl_sync <= 3'h0;
      frame_count <= 16'h0;
    end
    else
    begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
      if (tgl_sync[2] != tgl_sync[1])
        frame_count <= frame_count + 16'h1;
    end
  end

  // ==========================================================
  // bit timing, link domain
  logic drive_clk;
  logic phase;
  logic tick;
  assign drive_clk = cfg_l.master & ~cfg_l.mux;
  // master halves the link clock; a gap freezes both the clock and the data
  assign tick = drive_clk ? (phase & ~i_rx_gap) : 1'b1;

  always_ff @(posedge i_clk_link)
  begin
    if (!lrst_n)
    begin
      phase <= 1'b0;
      o_rx_sys_clock <= 1'b0;
      o_rx_sys_clock_oe <= 1'b0;
    end
    else
    begin
      o_rx_sys_clock_oe <= drive_clk; // see R14
      if (!i_rx_gap)
      begin
        phase <= ~phase;
        o_rx_sys_clock <= drive_clk & phase; // see R14
      end
    end
  end

  // ==========================================================
  // external frame start sampling
  logic ext_q;
  logic ext_prev;
  logic ext_start;
  logic frame_start;

  always_ff @(posedge i_clk_link)
  begin
    if (!lrst_n)
    begin
      ext_q <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      // see R10, R12: sampled on the active edge of the link or bus clock
      ext_q <= (cfg_l.mux ? i_rx_bus_frame_pulse_muxed : i_rx_sys_frame_pulse) ^
        cfg_l.pol_inv; // see R11, R13
      ext_prev <= ext_q;
    end
  end

  assign ext_start = ext_q & ~ext_prev;
  // see R7, R9, R12: each pulse restarts the frame
  assign frame_start = drive_clk ? i_rx_frame_start : ext_start;

  // ==========================================================
  // frame position
  logic fbit;
  logic [2:0] bitc;
  logic [1:0] slot;
  logic [4:0] chan;
  logic next_fbit;
  logic [2:0] next_bitc;
  logic [1:0] next_slot;
  logic [4:0] next_chan;
  logic next_first;
  logic [4:0] chan_last;
  logic t1_fbit;

  assign t1_fbit = ~cfg_l.e1 & ~cfg_l.mux;
  assign chan_last = (cfg_l.e1 | cfg_l.mux) ? rsti_pkg::E1_CHAN_LAST : rsti_pkg::T1_CHAN_LAST;

  always_comb
  begin
    next_fbit = 1'b0;
    next_bitc = bitc;
    next_slot = slot;
    next_chan = chan;
    next_first = 1'b0;
    if (frame_start)
    begin
      next_fbit = t1_fbit;
      next_bitc = 3'h0;
      next_slot = 2'h0;
      next_chan = 5'h0;
      next_first = 1'b1;
    end
    else if (fbit)
      next_bitc = 3'h0;
    else if (bitc != rsti_pkg::BIT_LAST)
      next_bitc = bitc + 3'h1;
    else
    begin
      next_bitc = 3'h0;
      if (cfg_l.mux && slot != rsti_pkg::LINK_LAST)
        next_slot = slot + 2'h1;
      else
      begin
        next_slot = 2'h0;
        if (chan == chan_last)
        begin
          next_chan = 5'h0;
          next_fbit = t1_fbit;
          next_first = 1'b1;
        end
        else
          next_chan = chan + 5'h1;
      end
    end
  end

  always_ff @(posedge i_clk_link)
  begin
    if (!lrst_n)
    begin
      fbit <= 1'b0;
      bitc <= 3'h0;
      slot <= 2'h0;
      chan <= 5'h0;
    end
    else if (tick)
    begin
      fbit <= next_fbit;
      bitc <= next_bitc;
      slot <= next_slot;
      chan <= next_chan;
    end
  end

  // ==========================================================
  // serialiser
  logic own_slot;
  logic load;
  logic [7:0] data_sh;
  logic [7:0] sig_sh;
  logic out_bit;
  logic out_sig;

  // see R2: only the configured slot of each channel time carries this link
  assign own_slot = ~cfg_l.mux | (next_slot == cfg_l.slot);
  assign load = tick & ~next_fbit & (next_bitc == 3'h0) & own_slot;
  // see R3: b1 leads, the nibble fills b5 to b8, b1 to b4 stay low
  assign out_bit = load ? i_chan.data[7] : (next_fbit ? i_rx_fbit : data_sh[7]);
  assign out_sig = load ? 1'b0 : (next_fbit ? 1'b0 : sig_sh[7]);

  always_ff @(posedge i_clk_link)
  begin
    if (!lrst_n)
    begin
      data_sh <= 8'h0;
      sig_sh <= 8'h0;
      o_chan_req <= 1'b0;
      o_chan_idx <= 5'h0;
    end
    else
    begin
      o_chan_req <= load;
      if (load)
      begin
        data_sh <= {i_chan.data[6:0], 1'b0};
        sig_sh <= {4'h0, i_chan.sig[3:0]} << 1;
        // ask one channel ahead so the core has a whole byte time to answer
        o_chan_idx <= (next_chan == chan_last) ? 5'h0 : next_chan + 5'h1;
      end
      else if (tick && !next_fbit)
      begin
        data_sh <= {data_sh[6:0], 1'b0};
        sig_sh <= {sig_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk_link)
  begin
    if (!lrst_n)
    begin
      o_rx_sys_data <= 1'b0;
      o_rx_sys_signaling <= 1'b0;
      o_rx_bus_data_muxed <= 1'b0;
      o_rx_bus_signaling_muxed <= 1'b0;
      o_rx_bus_data_muxed_oe <= 1'b0;
      o_rx_bus_signaling_muxed_oe <= 1'b0;
    end
    else if (tick)
    begin
      o_rx_sys_data <= ~cfg_l.mux & out_bit; // see R1
      o_rx_sys_signaling <= ~cfg_l.mux & out_sig; // see R4
      o_rx_bus_data_muxed <= cfg_l.mux & own_slot & out_bit; // see R2
      o_rx_bus_signaling_muxed <= cfg_l.mux & own_slot & out_sig; // see R5
      o_rx_bus_data_muxed_oe <= cfg_l.mux & own_slot;
      o_rx_bus_signaling_muxed_oe <= cfg_l.mux & own_slot; // see R5
    end
  end

  // ==========================================================
  // frame pulse generation
  logic frm_par;
  logic mf_par;
  logic evt_hit;
  logic is_frame0;

  assign is_frame0 = next_first;

  always_comb
  begin
    evt_hit = 1'b0;
    if (!cfg_l.e1)
    begin
      // see R6
      unique case (cfg_l.evt)
        rsti_pkg::EVT_EVERY: evt_hit = is_frame0;
        rsti_pkg::EVT_SECOND: evt_hit = is_frame0 & ~frm_par;
        rsti_pkg::EVT_MF: evt_hit = is_frame0 & i_rx_mf_start;
        rsti_pkg::EVT_SECOND_MF: evt_hit = is_frame0 & i_rx_mf_start & ~mf_par;
        default: evt_hit = 1'b0;
      endcase
    end
    else
    begin
      // see R8
      unique case (cfg_l.evt)
        rsti_pkg::EVT_EVERY: evt_hit = is_frame0;
        rsti_pkg::EVT_E1_CRC_MF: evt_hit = is_frame0 & i_rx_mf_start;
        rsti_pkg::EVT_E1_SIG_MF: evt_hit = is_frame0 & i_rx_sig_mf_start;
        rsti_pkg::EVT_E1_BOTH: evt_hit = is_frame0 & (i_rx_mf_start | i_rx_sig_mf_start);
        rsti_pkg::EVT_E1_TS: evt_hit = (next_bitc == 3'h0) & ~next_first &
          ((next_chan == rsti_pkg::E1_TS1) | (next_chan == rsti_pkg::E1_TS16));
        default: evt_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk_link)
  begin
    if (!lrst_n)
    begin
      frm_par <= 1'b0;
      mf_par <= 1'b0;
      frame_tgl <= 1'b0;
      o_rx_sys_frame_pulse <= 1'b0;
      o_rx_sys_frame_pulse_oe <= 1'b0;
    end
    else
    begin
      o_rx_sys_frame_pulse_oe <= drive_clk; // see R10
      if (tick)
      begin
        if (is_frame0)
        begin
          frm_par <= ~frm_par;
          frame_tgl <= ~frame_tgl;
          if (i_rx_mf_start)
            mf_par <= ~mf_par;
        end
        // see R17: held for exactly the bit period of the event
        o_rx_sys_frame_pulse <= (drive_clk & evt_hit) ^ cfg_l.pol_inv; // see R10, R11
      end
    end
  end

  // ==========================================================
  // checks
  logic fp_act;
  assign fp_act = o_rx_sys_frame_pulse ^ cfg_l.pol_inv;

  a_sys_data_edge: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R1
    $changed(o_rx_sys_data) && $stable(cfg_l) |-> $past(tick))
    else $error("serial data changed off the active edge");
  a_mux_slot_width: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R2
    cfg_l.mux && $stable(cfg_l) && $rose(o_rx_bus_data_muxed_oe) |->
      o_rx_bus_data_muxed_oe[*8] ##1 !o_rx_bus_data_muxed_oe)
    else $error("multiplexed slot not eight bits wide");
  a_sig_upper_low: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R3
    !fbit && bitc < rsti_pkg::SIG_FIRST_BIT && $past(tick) |-> !o_rx_sys_signaling)
    else $error("signaling bit outside b5 to b8");
  a_sig_edge: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R4
    $changed(o_rx_sys_signaling) && $stable(cfg_l) |-> $past(tick))
    else $error("signaling changed off the active edge");
  a_msig_align: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R5
    o_rx_bus_signaling_muxed_oe == o_rx_bus_data_muxed_oe)
    else $error("multiplexed signaling not aligned with data");
  a_fp_every_frame: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R6
    drive_clk && $stable(cfg_l) && cfg_l.evt == rsti_pkg::EVT_EVERY && fp_act |->
      bitc == 3'h0 && chan == 5'h0)
    else $error("frame pulse away from frame start");
  a_slave_restart: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R7, R9, R12
    !drive_clk && ext_start |=> bitc == 3'h0 && chan == 5'h0 && slot == 2'h0)
    else $error("external pulse did not restart frame");
  a_fp_oe_mode: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R10
    $stable(drive_clk) |=> o_rx_sys_frame_pulse_oe == $past(drive_clk))
    else $error("frame pulse direction wrong");
  a_fp_idle_pol: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R11
    !drive_clk && $stable(cfg_l) && $past(tick) |-> o_rx_sys_frame_pulse == cfg_l.pol_inv)
    else $error("idle frame pulse level wrong");
  a_clk_data_edge: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R14
    drive_clk && $stable(cfg_l) && $rose(o_rx_sys_clock) |-> $past(tick))
    else $error("system clock rose without a data update");
  a_fp_one_bit: assert property (@(posedge i_clk_link) disable iff (!lrst_n) // see R17
    drive_clk && $stable(cfg_l) && cfg_l.evt == rsti_pkg::EVT_EVERY && $rose(fp_act) |->
      fp_act ##1 fp_act ##1 !fp_act)
    else $error("frame pulse not one bit wide");
endmodule
`default_nettype wire

//--- verification/rsti_bp_model.sv
/*
  System backplane model: drives the external frame pulses and watches the driven one.
  Assumes the bench says when the sys pulse pin may be driven and which polarity is set.
*/
`timescale 1ns/100ps
`default_nettype none
module rsti_bp_model (
  input wire logic i_clk_link,
  input wire logic i_pol_inv,
  input wire logic i_drive_sys,
  input wire logic i_req_sys,
  input wire logic i_req_bus,
  input wire logic i_dev_fp,
  input wire logic i_dev_fp_oe,
  input wire logic i_mon_en,
  output logic o_fp_wire,
  output logic o_bus_fp,
  output logic [7:0] o_fp_count,
  output logic [7:0] o_bad_width
);
  logic act;
  logic act_q;
  logic [7:0] width;
  // ==========================================================
  // pins
  // a released pin floats to its pull-up, never to the last driven level
  assign o_fp_wire = i_dev_fp_oe ? i_dev_fp : (i_drive_sys ? i_req_sys ^ i_pol_inv : 1'b1);
  assign o_bus_fp = i_req_bus ^ i_pol_inv;
  assign act = o_fp_wire ^ i_pol_inv;
  // ==========================================================
  // frame pulse monitor: counts active starts, flags widths other than one bit
  always_ff @(posedge i_clk_link)
  begin
    act_q <= act;
    if (!i_mon_en)
    begin
      o_fp_count <= 8'h00;
      o_bad_width <= 8'h00;
      width <= 8'h00;
    end
    else if (act && !act_q)
    begin
      o_fp_count <= o_fp_count + 8'h01;
      width <= 8'h01;
    end
    else if (act && width != 8'h00)
      width <= width + 8'h01;
    else if (!act && act_q && width != 8'h02 && width != 8'h00)
      o_bad_width <= o_bad_width + 8'h01;
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
/*
  Testbench of the receive system TDM interface: registers, master pulse events,
  slave and multiplexed serial output.
  Assumes the design's contract: one tick per link edge in slave/mux, two edges in master.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {logic e1; logic [2:0] evt; logic pol; logic [7:0] cnt;} rsti_row_t;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic fs = 1'b0;
  logic mf = 1'b0;
  logic smf = 1'b0;
  rsti_pkg::rsti_chan_t chan = '0;
  logic chan_req, sclk, sclk_oe, sdata, ssig, fp, fp_oe, fp_wire, bus_fp;
  logic mdata, mdata_oe, msig;
  logic pol = 1'b0;
  logic drive_sys = 1'b0;
  logic req_sys = 1'b0;
  logic req_bus = 1'b0;
  logic mon_en = 1'b0;
  logic [7:0] fp_count, bad_width;
  logic [4:0] chan_idx;
  logic [31:0] d0, d;
  int flen = 256;
  int tcnt = 0;
  logic [1:0] fcnt = 2'h0;
  int n_errors = 0;
  int tests_run = 0;
  // the window covers 4 frames, a whole period of every event, so each count is exact
  rsti_row_t rows [9] = '{
    '{1'b0, rsti_pkg::EVT_EVERY, 1'b0, 8'h04}, '{1'b0, rsti_pkg::EVT_SECOND, 1'b0, 8'h02},
    '{1'b0, rsti_pkg::EVT_MF, 1'b0, 8'h02}, '{1'b0, rsti_pkg::EVT_SECOND_MF, 1'b0, 8'h01},
    '{1'b1, rsti_pkg::EVT_EVERY, 1'b0, 8'h04}, '{1'b1, rsti_pkg::EVT_E1_CRC_MF, 1'b0, 8'h02},
    '{1'b1, rsti_pkg::EVT_E1_SIG_MF, 1'b0, 8'h01}, '{1'b1, rsti_pkg::EVT_E1_BOTH, 1'b0, 8'h02},
    '{1'b1, rsti_pkg::EVT_E1_TS, 1'b1, 8'h08}};

  always #2 clk_sys = ~clk_sys;
  always #3 clk_link = ~clk_link;

  rsti_top u_dut (.i_clk_sys(clk_sys), .i_resetn(resetn), .i_addr(addr), .i_wr_data(wdata),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_clk_link(clk_link), .i_rx_gap(1'b0),
    .i_rx_frame_start(fs), .i_rx_mf_start(mf), .i_rx_sig_mf_start(smf), .i_rx_fbit(1'b0),
    .i_chan(chan), .o_chan_req(chan_req), .o_chan_idx(chan_idx), .o_rx_sys_clock(sclk),
    .o_rx_sys_clock_oe(sclk_oe), .o_rx_sys_data(sdata), .o_rx_sys_signaling(ssig),
    .i_rx_sys_frame_pulse(fp_wire), .o_rx_sys_frame_pulse(fp), .o_rx_sys_frame_pulse_oe(fp_oe),
    .i_rx_bus_frame_pulse_muxed(bus_fp), .o_rx_bus_data_muxed(mdata),
    .o_rx_bus_data_muxed_oe(mdata_oe), .o_rx_bus_signaling_muxed(msig),
    .o_rx_bus_signaling_muxed_oe());

  rsti_bp_model u_bp (.i_clk_link(clk_link), .i_pol_inv(pol), .i_drive_sys(drive_sys),
    .i_req_sys(req_sys), .i_req_bus(req_bus), .i_dev_fp(fp), .i_dev_fp_oe(fp_oe),
    .i_mon_en(mon_en), .o_fp_wire(fp_wire), .o_bus_fp(bus_fp), .o_fp_count(fp_count),
    .o_bad_width(bad_width));

  // ==========================================================
  // framer core stand-in: channel bytes and frame boundaries on the tick
  always_ff @(posedge clk_link)
  begin
    chan <= '{data: {chan_idx, 3'h5}, sig: chan_idx[3:0] ^ 4'ha};
    if (!sclk)
      tcnt <= (tcnt >= flen - 1) ? 0 : tcnt + 1;
    else
    begin
      // set one edge early so the flags are seen on the tick edge itself
      fs <= (tcnt == flen - 1);
      mf <= (tcnt == flen - 1) && fcnt[0];
      smf <= (tcnt == flen - 1) && (fcnt == 2'h3);
      if (tcnt == flen - 1)
        fcnt <= fcnt + 2'h1;
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // one external pulse, then one channel byte read off the wire, b1 first
  task automatic cap(input logic mux, input int skip, input logic [4:0] ch);
    logic [7:0] dv, sv, ov;
    @(posedge clk_link);
    req_sys <= !mux;
    req_bus <= mux;
    @(posedge clk_link);
    req_sys <= 1'b0;
    req_bus <= 1'b0;
    // the pulse restarts the frame one edge after it is sampled, so b1 of the
    // wanted byte shows skip - 2 edges after the release of the request
    repeat (skip - 3) @(posedge clk_link);
    #1;
    if (mux)
      check("oe before slot", mdata_oe, 1'b0);
    @(posedge clk_link);
    #1;
    for (int j = 0; j < 8; j++)
    begin
      dv[7 - j] = mux ? mdata : sdata;
      sv[7 - j] = mux ? msig : ssig;
      ov[7 - j] = mdata_oe;
      @(posedge clk_link);
      #1;
    end
    check("data byte", dv, {ch, 3'h5});
    check("sig nibble", sv, {4'h0, ch[3:0] ^ 4'ha});
    if (mux)
      check("slot oe", ov, 8'hff);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    repeat (80000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    reg_rd(rsti_pkg::ADDR_MODE, d);
    check("mode reset", d, rsti_pkg::MODE_RESET);
    reg_rd(rsti_pkg::ADDR_POL, d);
    check("pol reset", d, rsti_pkg::POL_RESET);
    reg_wr(8'h4c, 32'hffffffff);
    reg_rd(8'h4c, d);
    check("unmapped", d, 32'h0);
    $display("test registers done");
    foreach (rows[i])
    begin
      flen = rows[i].e1 ? 256 : 193;
      pol = rows[i].pol;
      reg_wr(rsti_pkg::ADDR_POL, {27'h0, rows[i].pol, 4'h0});
      // mode: slot 9:8, event 6:4, e1 b2, master b1, mux b0
      reg_wr(rsti_pkg::ADDR_MODE, {25'h0, rows[i].evt, 1'b0, rows[i].e1, 2'h2});
      reg_rd(rsti_pkg::ADDR_POL, d);
      check("pol readback", d, {27'h0, rows[i].pol, 4'h0});
      repeat (2 * flen) @(posedge clk_link);
      mon_en <= 1'b1;
      repeat (8 * flen) @(posedge clk_link);
      check("fp count", fp_count, rows[i].cnt);
      check("fp width", bad_width, 8'h00);
      check("fp oe", fp_oe, 1'b1);
      check("clock oe", sclk_oe, 1'b1);
      mon_en <= 1'b0;
      $display("test master row %0d done", i);
    end
    flen = 256;
    pol = 1'b0;
    reg_wr(rsti_pkg::ADDR_POL, 32'h0);
    reg_wr(rsti_pkg::ADDR_MODE, 32'h4);
    drive_sys <= 1'b1;
    repeat (20) @(posedge clk_link);
    reg_rd(rsti_pkg::ADDR_STAT, d0);
    cap(1'b0, 11, 5'h01);
    cap(1'b0, 19, 5'h02);
    repeat (12) @(posedge clk_sys);
    reg_rd(rsti_pkg::ADDR_STAT, d);
    check("frame starts", d[15:0], d0[15:0] + 16'h2);
    $display("test slave done");
    pol = 1'b1;
    drive_sys <= 1'b0;
    reg_wr(rsti_pkg::ADDR_POL, 32'h10);
    reg_wr(rsti_pkg::ADDR_MODE, 32'h205);
    repeat (20) @(posedge clk_link);
    cap(1'b1, 51, 5'h01);
    $display("test multiplexed done");
    print_verdict();
  end
endmodule
`default_nettype wire
